/* File: rtl/tmc_edge_sync.sv */
// Two-stage synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin; pulses are one clock wide.
`timescale 1ns/1ps
`default_nettype none
module tmc_edge_sync (
	input  wire logic i_ref_clk,	// System clock
	input  wire logic i_rst_n,	// Sync reset, active low
	input  wire logic i_pin,	// Asynchronous input
	output logic      o_rise,	// One-cycle rising pulse
	output logic      o_fall	// One-cycle falling pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// First stage feeds only the second
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign o_rise = sync_q & ~last_q;
	assign o_fall = ~sync_q & last_q;
endmodule // tmc_edge_sync
`default_nettype wire

/* File: rtl/tmc_match_ch.sv */
// One match channel: comparator and its external output action.
// Assumes the step pulse marks each count update.
`timescale 1ns/1ps
`default_nettype none
module tmc_match_ch (
	input  wire logic        i_ref_clk,	// System clock
	input  wire logic        i_rst_n,	// Sync reset, active low
	input  wire logic        i_step,	// Count update pulse
	input  wire logic [31:0] i_count,	// Current count
	input  wire logic [31:0] i_match,	// Match value
	input  wire logic [1:0]  i_action,	// Output action
	input  wire logic        i_load,	// Software load of pin state
	input  wire logic        i_load_val,	// Value to load
	output logic             o_hit,	// Match event pulse
	output logic             o_pin	// Match output, registered
);
	import tmc_pkg::*;

	assign o_hit = i_step & (i_count == i_match);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_pin <= 1'b0;
		end else if (o_hit) begin
			case (i_action)
				ACT_LOW:    o_pin <= 1'b0;
				ACT_HIGH:   o_pin <= 1'b1;
				ACT_TOGGLE: o_pin <= ~o_pin;
				default:    o_pin <= o_pin;
			endcase
		end else if (i_load) begin
			o_pin <= i_load_val;
		end
	end
endmodule // tmc_match_ch
`default_nettype wire

/* File: rtl/tmc_pkg.sv */
// Constants, types and register map of the 32-bit timer/counter.
// Assumes a single 200 MHz clock and a plain strobe register port.
//
// Overview of operation
// - 32-bit count steps once per (prescale value + 1) source ticks.
// - Timer mode counts clock cycles; counter mode counts external input edges.
// - Two capture registers load the count on their input's transition.
// - Capture events raise an interrupt when their mask bit is set.
// - Four match registers compared against the count signal match events.
// - Match without stop or reset keeps counting, optional interrupt.
// - Match with stop halts count and prescaler, optional interrupt.
// - Match with reset returns count to zero and continues, optional interrupt.
// - Four match outputs go low, high, toggle or hold on their match.
package tmc_pkg;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tmc_bus_req_s;

	typedef enum logic [2:0] {
		ST_STOP  = 3'b001,
		ST_RUN   = 3'b010,
		ST_CLEAR = 3'b100
	} tmc_run_e;

	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_MODE     = 8'h04;
	localparam logic [7:0] OFS_COUNT    = 8'h08;
	localparam logic [7:0] OFS_PRESCALE = 8'h0C;
	localparam logic [7:0] OFS_PCOUNT   = 8'h10;
	localparam logic [7:0] OFS_MATCH_CTL = 8'h14;
	localparam logic [7:0] OFS_MATCH0   = 8'h18;
	localparam logic [7:0] OFS_MATCH1   = 8'h1C;
	localparam logic [7:0] OFS_MATCH2   = 8'h20;
	localparam logic [7:0] OFS_MATCH3   = 8'h24;
	localparam logic [7:0] OFS_CAP_CTL  = 8'h28;
	localparam logic [7:0] OFS_CAP0     = 8'h2C;
	localparam logic [7:0] OFS_CAP1     = 8'h30;
	localparam logic [7:0] OFS_EXT_CTL  = 8'h34;
	localparam logic [7:0] OFS_INT_STAT = 8'h38;
	localparam logic [7:0] OFS_INT_MASK = 8'h3C;

	// CTRL fields
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CLR_BIT = 1;
	// MODE fields: bit 0 counter mode, bits 2:1 count edge (bit1 rise, bit2 fall)
	localparam int MODE_CNT_BIT  = 0;
	localparam int MODE_RISE_BIT = 1;
	localparam int MODE_FALL_BIT = 2;
	localparam logic [2:0] MODE_RST = 3'h2;
	// MATCH_CTL: bits 3:0 reset on match, bits 7:4 stop on match
	localparam int MCTL_RST_LSB  = 0;
	localparam int MCTL_STOP_LSB = 4;
	// CAP_CTL: two bits per channel, low bit rise, high bit fall
	localparam logic [3:0] CAP_CTL_RST = 4'h5;
	// EXT_CTL: bits 3:0 pin states, bits 11:4 two-bit action per pin
	localparam int EXT_ACT_LSB = 4;
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// INT_STAT / INT_MASK: bits 3:0 match, bits 5:4 capture
	localparam int INT_MATCH_LSB = 0;
	localparam int INT_CAP_LSB   = 4;
	localparam int INT_W         = 6;

	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam int NUM_MATCH = 4;
	localparam int NUM_CAP   = 2;
endpackage

/* File: rtl/tmc_timer.sv */
// Top of the 32-bit timer/counter: registers, prescaler, count,
// capture, match actions and interrupt.
// Assumes the bus master obeys one-cycle strobes, never both at once.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
	input  wire logic                  i_ref_clk,	// 200 MHz clock
	input  wire logic                  i_rst_n,	// Sync reset, active low
	input  wire tmc_pkg::tmc_bus_req_s i_bus,	// Register request
	output logic [31:0]                o_rdata,	// Read data, cycle after rd
	output logic                       o_irq,	// Interrupt, level
	input  wire logic                  i_cnt_pin,	// External count clock
	input  wire logic [1:0]            i_cap_pin,	// Capture inputs
	output logic [3:0]                 o_match_pin	// Match outputs
);
	import tmc_pkg::*;

	tmc_run_e          st_q;
	logic [1:0]        ctrl_q;
	logic [2:0]        mode_q;
	logic [31:0]       tc_q;
	logic [31:0]       pr_q;
	logic [31:0]       pc_q;
	logic [7:0]        mctl_q;
	logic [31:0]       mr_q [NUM_MATCH];
	logic [3:0]        capctl_q;
	logic [31:0]       cap_q [NUM_CAP];
	logic [7:0]        ext_act_q;
	logic [INT_W-1:0]  stat_q;
	logic [INT_W-1:0]  stat_d;
	logic [INT_W-1:0]  mask_q;
	logic [31:0]       rdata_q;
	logic              irq_q;

	logic              cnt_rise;
	logic              cnt_fall;
	logic [1:0]        cap_rise;
	logic [1:0]        cap_fall;
	logic [1:0]        cap_evt;
	logic              src_tick;
	logic              step;
	logic [3:0]        hit;
	logic [3:0]        rst_en;
	logic [3:0]        stop_en;
	logic              wr_ctrl;
	logic              wr_count;
	logic              wr_ext;

	assign rst_en   = mctl_q[MCTL_RST_LSB +: NUM_MATCH];
	assign stop_en  = mctl_q[MCTL_STOP_LSB +: NUM_MATCH];
	assign wr_ctrl  = i_bus.wr && (i_bus.addr == OFS_CTRL);
	assign wr_count = i_bus.wr && (i_bus.addr == OFS_COUNT);
	assign wr_ext   = i_bus.wr && (i_bus.addr == OFS_EXT_CTL);

	// External inputs
	tmc_edge_sync u_cnt_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_cnt_pin),
		.o_rise    (cnt_rise),
		.o_fall    (cnt_fall)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CAP; gi++) begin : g_cap_sync
			tmc_edge_sync u_cap_sync (
				.i_ref_clk (i_ref_clk),
				.i_rst_n   (i_rst_n),
				.i_pin     (i_cap_pin[gi]),
				.o_rise    (cap_rise[gi]),
				.o_fall    (cap_fall[gi])
			);
			assign cap_evt[gi] = (cap_rise[gi] & capctl_q[2*gi])
				| (cap_fall[gi] & capctl_q[2*gi+1]);
		end
	endgenerate

	// Count source and prescaler rollover
	always_comb begin
		if (mode_q[MODE_CNT_BIT]) begin
			src_tick = (cnt_rise & mode_q[MODE_RISE_BIT])
				| (cnt_fall & mode_q[MODE_FALL_BIT]);
		end else begin
			src_tick = 1'b1;
		end
	end

	assign step = (st_q == ST_RUN) && src_tick && (pc_q >= pr_q);

	generate
		for (gi = 0; gi < NUM_MATCH; gi++) begin : g_match
			tmc_match_ch u_match (
				.i_ref_clk  (i_ref_clk),
				.i_rst_n    (i_rst_n),
				.i_step     (step),
				.i_count    (tc_q),
				.i_match    (mr_q[gi]),
				.i_action   (ext_act_q[2*gi +: 2]),
				.i_load     (wr_ext),
				.i_load_val (i_bus.wdata[gi]),
				.o_hit      (hit[gi]),
				.o_pin      (o_match_pin[gi])
			);
		end
	endgenerate

	// Run state follows CTRL; a stop match drops the enable
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= 2'h0;
		end else if (wr_ctrl) begin
			ctrl_q <= i_bus.wdata[1:0];
		end else if (|(hit & stop_en)) begin
			ctrl_q[CTRL_EN_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_q <= ST_STOP;
		end else begin
			case (st_q)
				ST_RUN: begin
					if (|(hit & stop_en)) begin
						st_q <= ST_STOP;
					end else if (wr_ctrl && i_bus.wdata[CTRL_CLR_BIT]) begin
						st_q <= ST_CLEAR;
					end else if (wr_ctrl && !i_bus.wdata[CTRL_EN_BIT]) begin
						st_q <= ST_STOP;
					end
				end
				ST_STOP, ST_CLEAR: begin
					if (wr_ctrl) begin
						if (i_bus.wdata[CTRL_CLR_BIT]) begin
							st_q <= ST_CLEAR;
						end else if (i_bus.wdata[CTRL_EN_BIT]) begin
							st_q <= ST_RUN;
						end else begin
							st_q <= ST_STOP;
						end
					end
				end
				default: st_q <= ST_STOP;
			endcase
		end
	end

	// Prescale counter; zeroed while cleared, held while stopped
	// A stale value above a newly lowered limit wraps at once, not after 2^32 ticks
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || st_q == ST_CLEAR) begin
			pc_q <= WORD_RST;
		end else if (st_q == ST_RUN && src_tick) begin
			pc_q <= (pc_q >= pr_q) ? WORD_RST : pc_q + 32'h1;
		end
	end

	// Main count; a reset match wins over the increment
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || st_q == ST_CLEAR) begin
			tc_q <= WORD_RST;
		end else if (wr_count) begin
			tc_q <= i_bus.wdata;
		end else if (step) begin
			if (|(hit & rst_en)) begin
				tc_q <= WORD_RST;
			end else begin
				tc_q <= tc_q + 32'h1;
			end
		end
	end

	// Capture registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cap_q[0] <= WORD_RST;
			cap_q[1] <= WORD_RST;
		end else begin
			for (int i = 0; i < NUM_CAP; i++) begin
				if (cap_evt[i]) begin
					cap_q[i] <= tc_q;
				end
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			mode_q    <= MODE_RST;
			pr_q      <= WORD_RST;
			mctl_q    <= 8'h00;
			capctl_q  <= CAP_CTL_RST;
			ext_act_q <= 8'h00;
			mask_q    <= '0;
			for (int i = 0; i < NUM_MATCH; i++) begin
				mr_q[i] <= WORD_RST;
			end
		end else if (i_bus.wr) begin
			case (i_bus.addr)
				OFS_MODE:      mode_q    <= i_bus.wdata[2:0];
				OFS_PRESCALE:  pr_q      <= i_bus.wdata;
				OFS_MATCH_CTL: mctl_q    <= i_bus.wdata[7:0];
				OFS_MATCH0:    mr_q[0]   <= i_bus.wdata;
				OFS_MATCH1:    mr_q[1]   <= i_bus.wdata;
				OFS_MATCH2:    mr_q[2]   <= i_bus.wdata;
				OFS_MATCH3:    mr_q[3]   <= i_bus.wdata;
				OFS_CAP_CTL:   capctl_q  <= i_bus.wdata[3:0];
				OFS_EXT_CTL:   ext_act_q <= i_bus.wdata[EXT_ACT_LSB +: 8];
				OFS_INT_MASK:  mask_q    <= i_bus.wdata[INT_W-1:0];
				default:       mask_q    <= mask_q;
			endcase
		end
	end

	// Sticky status: a new event beats a same-cycle clear
	always_comb begin
		stat_d = stat_q;
		if (i_bus.wr && i_bus.addr == OFS_INT_STAT) begin
			stat_d = stat_q & ~i_bus.wdata[INT_W-1:0];
		end
		stat_d[INT_MATCH_LSB +: NUM_MATCH] = stat_d[INT_MATCH_LSB +: NUM_MATCH] | hit;
		stat_d[INT_CAP_LSB +: NUM_CAP] = stat_d[INT_CAP_LSB +: NUM_CAP] | cap_evt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			stat_q <= '0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q  <= |(stat_q & mask_q);
		end
	end
	assign o_irq = irq_q;

	// Read port; unmapped addresses read zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rdata_q <= WORD_RST;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				OFS_CTRL:      rdata_q <= {27'h0, st_q, ctrl_q};
				OFS_MODE:      rdata_q <= {29'h0, mode_q};
				OFS_COUNT:     rdata_q <= tc_q;
				OFS_PRESCALE:  rdata_q <= pr_q;
				OFS_PCOUNT:    rdata_q <= pc_q;
				OFS_MATCH_CTL: rdata_q <= {24'h0, mctl_q};
				OFS_MATCH0:    rdata_q <= mr_q[0];
				OFS_MATCH1:    rdata_q <= mr_q[1];
				OFS_MATCH2:    rdata_q <= mr_q[2];
				OFS_MATCH3:    rdata_q <= mr_q[3];
				OFS_CAP_CTL:   rdata_q <= {28'h0, capctl_q};
				OFS_CAP0:      rdata_q <= cap_q[0];
				OFS_CAP1:      rdata_q <= cap_q[1];
				OFS_EXT_CTL:   rdata_q <= {20'h0, ext_act_q, o_match_pin};
				OFS_INT_STAT:  rdata_q <= {26'h0, stat_q};
				OFS_INT_MASK:  rdata_q <= {26'h0, mask_q};
				default:       rdata_q <= WORD_RST;
			endcase
		end else begin
			rdata_q <= WORD_RST;
		end
	end
	assign o_rdata = rdata_q;

	// Checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	chk_prescale_roll: assert property (
		step |=> pc_q == 32'h0
	) else $error("prescaler did not roll over with the count step");

	chk_count_advance: assert property (
		(step && !(|(hit & rst_en)) && !wr_count) |=> tc_q == $past(tc_q) + 32'h1
	) else $error("count did not advance by one on step");

	chk_timer_source: assert property (
		(st_q == ST_RUN && !mode_q[MODE_CNT_BIT] && pr_q == 32'h0 && !wr_count
			&& !wr_ctrl && !(|(hit & (rst_en | stop_en))))
		|=> tc_q == $past(tc_q) + 32'h1
	) else $error("timer mode missed a clock cycle");

	chk_counter_source: assert property (
		(mode_q[MODE_CNT_BIT] && !cnt_rise && !cnt_fall) |-> !step
	) else $error("counter mode stepped without an input edge");

	chk_capture_load: assert property (
		cap_evt[0] |=> cap_q[0] == $past(tc_q)
	) else $error("capture register did not take the count");

	chk_capture_irq: assert property (
		(cap_evt[1] && mask_q[INT_CAP_LSB+1])
		##1 (mask_q[INT_CAP_LSB+1] && stat_q[INT_CAP_LSB+1]) |=> o_irq
	) else $error("enabled capture event raised no interrupt");

	chk_keep_run: assert property (
		(hit[0] && !(|(hit & (rst_en | stop_en))) && !wr_ctrl) |=> st_q == ST_RUN
	) else $error("plain match disturbed counting");

	chk_stop_halt: assert property (
		(|(hit & stop_en) && !wr_ctrl) |=> ((st_q == ST_STOP) && !step) [*2]
	) else $error("stop match did not halt the timer");

	chk_reset_zero: assert property (
		(|(hit & rst_en) && !wr_count) |=> tc_q == 32'h0
	) else $error("reset match did not clear the count");

	chk_match_toggle: assert property (
		(hit[3] && ext_act_q[7:6] == ACT_TOGGLE) |=> o_match_pin[3] != $past(o_match_pin[3])
	) else $error("toggle action did not toggle the match output");

	chk_cap_edge_sel: assert property (
		(cap_fall[0] && !capctl_q[1]) |-> !cap_evt[0]
	) else $error("capture fired on a deselected edge");

	chk_sync_single: assert property (
		cnt_rise |=> !cnt_rise [*2]
	) else $error("one input edge gave more than one event");

	cov_capture: cover property (cap_evt[0] ##[1:20] cap_evt[0]);
	cov_stop: cover property (|(hit & stop_en));
	cov_reset: cover property (|(hit & rst_en) ##1 (tc_q == 32'h0));
	cov_counter: cover property (mode_q[MODE_CNT_BIT] && step);
endmodule // tmc_timer
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the timer/counter top, driven through its register port.
// Assumes 200 MHz clock, synchronous active-low reset, one-cycle read latency.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tmc_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	tmc_bus_req_s bus = '0;
	logic [31:0]  rdata;
	logic         irq;
	logic         cnt_pin = 1'b0;
	logic [1:0]   cap_pin = 2'h0;
	logic [3:0]   mpin;
	int           fail_count = 0;
	int           n_compared = 0;
	logic [31:0]  seed = 32'h586FBC47;
	logic [31:0]  v, m, e;
	logic [31:0]  exp_cap [2];
	logic [3:0]   ini;
	int           t, p;

	always #2.5 clk = ~clk;

	tmc_timer u_tmc_timer (
		.i_ref_clk  (clk),
		.i_rst_n    (rst_n),
		.i_bus      (bus),
		.o_rdata    (rdata),
		.o_irq      (irq),
		.i_cnt_pin  (cnt_pin),
		.i_cap_pin  (cap_pin),
		.o_match_pin(mpin)
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Poll until a stop-on-match clears the enable bit
	task automatic wait_stop();
		logic [31:0] c;
		int          i;
		c = 32'h1;
		for (i = 0; i < 60 && c[CTRL_EN_BIT]; i++) begin
			rd(OFS_CTRL, c);
		end
		if (c[CTRL_EN_BIT]) begin
			fail_count++;
			$display("FAIL stop_wait expected 0 seen 1");
			summarize();
		end
	endtask

	task automatic pulse_cap(input int c, input logic lvl);
		@(posedge clk);
		cap_pin[c] <= lvl;
		repeat (6) @(posedge clk);
	endtask

	initial begin
		#400000;
		fail_count++;
		$display("FAIL timeout expected done seen hang");
		summarize();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_MODE, v);
		check("mode_rst", v, {29'h0, MODE_RST});
		rd(OFS_CAP_CTL, v);
		check("capctl_rst", v, {28'h0, CAP_CTL_RST});
		rd(8'hFC, v);
		check("unmapped", v, 32'h0000_0000);
		check("irq_rst", {31'h0, irq}, 32'h0);
		// All four actions at once; stop on match freezes the count
		for (t = 0; t < 2; t++) begin
			ini = 4'(rnd());
			m = 32'h4 + (rnd() & 32'h7);
			wr(OFS_INT_MASK, 32'h0);
			wr(OFS_EXT_CTL, 32'h0000_0E40 | ini);
			@(negedge clk);
			check("pin_load", {28'h0, mpin}, {28'h0, ini});
			for (p = 0; p < 4; p++) begin
				wr(OFS_MATCH0 + 8'(4 * p), m);
			end
			wr(OFS_MATCH_CTL, 32'h0000_00F0);
			wr(OFS_PRESCALE, 32'h0);
			wr(OFS_COUNT, 32'h0);
			wr(OFS_INT_STAT, 32'h3F);
			wr(OFS_CTRL, 32'h1);
			wait_stop();
			check("pin_act", {28'h0, mpin}, {28'h0, ~ini[3], 2'b10, ini[0]});
			rd(OFS_INT_STAT, v);
			check("match_stat", v, 32'hF);
			rd(OFS_COUNT, e);
			repeat (10) @(posedge clk);
			rd(OFS_COUNT, v);
			check("stop_hold", v, e);
			check("irq_masked", {31'h0, irq}, 32'h0);
		end
		// Prescaled free run: count and prescale count after a known tick total
		wr(OFS_MATCH_CTL, 32'h0);
		for (t = 0; t < 4; t++) begin
			p = t;
			m = 20 + (rnd() & 32'h1F);
			wr(OFS_PRESCALE, p);
			wr(OFS_CTRL, 32'h2);
			wr(OFS_CTRL, 32'h1);
			repeat (m) @(posedge clk);
			wr(OFS_CTRL, 32'h0);
			rd(OFS_COUNT, v);
			check("count_presc", v, (m + 2) / (p + 1));
			rd(OFS_PCOUNT, v);
			check("pcount", v, (m + 2) % (p + 1));
		end
		// Reset on match keeps the count within 0..5
		wr(OFS_PRESCALE, 32'h0);
		wr(OFS_MATCH1, 32'h5);
		wr(OFS_MATCH_CTL, 32'h2);
		wr(OFS_INT_STAT, 32'h3F);
		wr(OFS_MATCH0, 32'h3);
		wr(OFS_INT_MASK, 32'h2);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h1);
		for (t = 0; t < 8; t++) begin
			rd(OFS_COUNT, v);
			check("count_wrap", {31'h0, v <= 32'h5}, 32'h1);
		end
		rd(OFS_CTRL, v);
		check("still_run", {31'h0, v[CTRL_EN_BIT]}, 32'h1);
		check("irq_match", {31'h0, irq}, 32'h1);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_INT_STAT, 32'h3F);
		repeat (2) @(posedge clk);
		check("irq_clr", {31'h0, irq}, 32'h0);
		// Capture edge selection with a frozen count
		wr(OFS_INT_MASK, 32'h30);
		exp_cap[0] = 32'h0;
		exp_cap[1] = 32'h0;
		for (t = 0; t < 6; t++) begin
			p = t % 2;
			m = 1 + t / 2;
			wr(OFS_CAP_CTL, m << (2 * p));
			for (int s = 0; s < 2; s++) begin
				v = rnd();
				wr(OFS_COUNT, v);
				pulse_cap(p, s == 0);
				if (m[s]) begin
					exp_cap[p] = v;
				end
				rd(OFS_INT_STAT, e);
				check("cap_stat", e, m[s] ? (32'h10 << p) : 32'h0);
				check("cap_irq", {31'h0, irq}, {31'h0, m[s]});
				rd(OFS_CAP0 + 8'(4 * p), e);
				check("cap_val", e, exp_cap[p]);
				wr(OFS_INT_STAT, 32'h3F);
				rd(OFS_INT_STAT, e);
				check("cap_once", e, 32'h0);
			end
		end
		// Counter mode: rise, fall and both edges, no reset match in the way
		wr(OFS_MATCH_CTL, 32'h0);
		for (t = 0; t < 3; t++) begin
			m = 3 + (rnd() % 5);
			wr(OFS_MODE, (t == 0) ? 32'h3 : (t == 1) ? 32'h5 : 32'h7);
			wr(OFS_COUNT, 32'h0);
			wr(OFS_CTRL, 32'h1);
			for (int i = 0; i < m; i++) begin
				cnt_pin <= 1'b1;
				repeat (3) @(posedge clk);
				cnt_pin <= 1'b0;
				repeat (3) @(posedge clk);
			end
			repeat (6) @(posedge clk);
			wr(OFS_CTRL, 32'h0);
			rd(OFS_COUNT, v);
			check("ext_count", v, (t == 2) ? 2 * m : m);
		end
		summarize();
	end
endmodule // tb
`default_nettype wire
